// file: rtl/tfc_core.sv
// Four-channel transfer controller sequencer with an APB register file.
// Assumes a bus engine that performs each granted unit and answers with a
// one-cycle done pulse (or error pulse) while the request stands.
// Notes on behaviour
// - Channel runs only with both enables set and end, error, NMI flags clear.
// - Each served request moves one sized unit and decrements the count.
// - Auto-request channels request internally once enabled.
// - Count reaching zero ends channel; end interrupt if enabled.
// - NMI or address error suspends all channels.
// - Clearing channel or master enable suspends transfers.
// - Source codes 0000, 0010, 0011 select external request modes.
// - External request detected by low level or falling edge per select bit.
// - Each external request gives one transfer on an enabled channel.
// - Codes 1100 to 1111 select the four peripheral requests.
// - Peripheral signal used as request is not forwarded as interrupt.
// - Peripheral request withdrawn at first unit (steal) or last (burst).
// - Arbiter grants exactly one pending channel by selected order.
// - Three fixed orders selected by the priority field.
// - Round robin moves the served channel to lowest priority.
// - Round robin starts with channel 0 highest after reset.
// - Serving channel 3 restores order with channel 3 lowest.
// - Priority codes 00, 01, 10 fixed; 11 round robin.
// - Error and NMI flags cleared only by writing 0 after reading 1.
// - NMI flag sets whether operating or halted.
//
// Chosen here: the APB slave port and the address map.
`timescale 1ns/100ps
module tfc_core (
  input  wire logic                 clk_in,
  input  wire logic                 rst_n_in,
  input  wire logic                 psel_in,
  input  wire logic                 penable_in,
  input  wire logic                 pwrite_in,
  input  wire logic [7:0]           paddr_in,
  input  wire logic [31:0]          pwdata_in,
  output logic      [31:0]          prdata_out,
  output logic                      pready_out,
  output logic                      pslverr_out,
  input  wire logic [tfc_pkg::NCH-1:0] external_request_n_in,
  input  wire logic                 nmi_in,
  input  wire logic                 serial_tx_empty_req_in,
  input  wire logic                 serial_rx_full_req_in,
  input  wire logic                 conversion_end_req_in,
  input  wire logic                 compare_match_req_in,
  output logic      [3:0]           periph_irq_out,
  output logic      [3:0]           periph_withdraw_out,
  output logic                      xfer_req_out,
  output logic      [1:0]           xfer_ch_out,
  output logic      [1:0]           xfer_size_out,
  input  wire logic                 xfer_done_in,
  input  wire logic                 xfer_addr_err_in,
  output logic      [tfc_pkg::NCH-1:0] request_acknowledge_out,
  output logic      [tfc_pkg::NCH-1:0] transfer_end_interrupt_out
);
  import tfc_pkg::*;

  logic [CNT_W-1:0] cnt_r [NCH];
  logic [NCH-1:0]   ce_r, te_r, ie_r, ds_r, burst_r;
  logic [1:0]       ts_r [NCH];
  logic [3:0]       rs_r [NCH];
  logic             me_r, nmi_flag_r, aef_r, nmi_flag_seen_r, aef_seen_r;
  logic [1:0]       pr_r;
  logic [1:0]       top_r;
  logic             lock_v_r;
  logic [1:0]       lock_ch_r;
  tfc_state_t       state_r;
  logic [1:0]       gnt_r;
  logic [3:0]       withdraw_r;
  logic [31:0]      rdata_r;
  logic             nmi_s1_r, nmi_s2_r, nmi_prev_r;

  logic [NCH-1:0]   ext_req, src_req, ready, served, is_ext, is_single;
  logic [3:0]       periph_in, periph_used;
  logic             enabled_all;
  logic             start, done;
  logic [2:0]       pick_res;
  logic [1:0]       gnt_nxt;
  logic             wr_acc, rd_setup;
  logic [1:0]       a_ch;
  logic             hit_cnt, hit_ctl, hit_op, hit_any;
  logic [31:0]      rd_mux;
  logic [CNT_W-1:0] cnt_g;

  // Pick first requesting channel by position; bit 2 says one was found
  function automatic logic [2:0] pick(input logic [1:0] pr, input logic [1:0] top,
                                      input logic [NCH-1:0] req);
    logic [7:0] ord;
    logic [1:0] ch;
    logic [2:0] res;
    ord = (pr == 2'h0) ? ORDER_0 : (pr == 2'h1) ? ORDER_1 : ORDER_2;
    res = 3'h0;
    for (int p = NCH - 1; p >= 0; p--) begin
      ch = (pr == PR_RR) ? 2'(top + 2'(p)) : ord[2*p +: 2];
      if (req[ch]) begin
        res = {1'b1, ch};
      end
    end
    return res;
  endfunction

  assign periph_in = {compare_match_req_in, conversion_end_req_in,
                      serial_rx_full_req_in, serial_tx_empty_req_in};

  // NMI pin crosses two flops before its edge is looked at
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      nmi_s1_r   <= 1'b0;
      nmi_s2_r   <= 1'b0;
      nmi_prev_r <= 1'b0;
    end else begin
      nmi_s1_r   <= nmi_in;
      nmi_s2_r   <= nmi_s1_r;
      nmi_prev_r <= nmi_s2_r;
    end
  end

  assign done        = (state_r == TFC_BUSY) & xfer_done_in;
  // Error and NMI flags gate every channel
  assign enabled_all = me_r & ~nmi_flag_r & ~aef_r;

  genvar c;
  generate
    for (c = 0; c < NCH; c++) begin : g_ch
      assign served[c]    = done & (gnt_r == 2'(c));
      assign is_ext[c]    = (rs_r[c] == RS_EXT_DUAL) | (rs_r[c] == RS_EXT_M2D) |
                            (rs_r[c] == RS_EXT_D2M);
      assign is_single[c] = (rs_r[c] == RS_EXT_M2D) | (rs_r[c] == RS_EXT_D2M);
      tfc_req_detect u_det (
        .clk_in       (clk_in),
        .rst_n_in     (rst_n_in),
        .req_n_in     (external_request_n_in[c]),
        .edge_mode_in (ds_r[c]),
        .served_in    (served[c]),
        .req_out      (ext_req[c])
      );
      assign src_req[c] = (rs_r[c] == RS_AUTO) | (is_ext[c] & ext_req[c]) |
                          ((rs_r[c][3:2] == RS_PERIPH_HI) & periph_in[rs_r[c][1:0]]);
      assign ready[c]   = enabled_all & ce_r[c] & ~te_r[c] & (cnt_r[c] != COUNT_RST) &
                          src_req[c];
      assign transfer_end_interrupt_out[c] = te_r[c] & ie_r[c];
      assign request_acknowledge_out[c]    = (state_r == TFC_BUSY) & (gnt_r == 2'(c)) &
                                             is_single[c];
    end
    for (c = 0; c < 4; c++) begin : g_src
      assign periph_used[c] = ((ce_r[0] & (rs_r[0] == {RS_PERIPH_HI, 2'(c)})) |
                               (ce_r[1] & (rs_r[1] == {RS_PERIPH_HI, 2'(c)})) |
                               (ce_r[2] & (rs_r[2] == {RS_PERIPH_HI, 2'(c)})) |
                               (ce_r[3] & (rs_r[3] == {RS_PERIPH_HI, 2'(c)})));
    end
  endgenerate

  // A signal taken as a request is kept from the processor
  assign periph_irq_out = periph_in & ~periph_used;

  // One grant by the selected order; burst holds its channel
  assign pick_res = pick(pr_r, top_r, ready);
  assign gnt_nxt  = (lock_v_r && ready[lock_ch_r]) ? lock_ch_r : pick_res[1:0];
  assign start    = (state_r == TFC_IDLE) & (|ready);
  assign cnt_g    = cnt_r[gnt_r];

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state_r <= TFC_IDLE;
      gnt_r   <= 2'h0;
    end else begin
      case (state_r)
        TFC_IDLE: begin
          if (start) begin
            state_r <= TFC_BUSY;
            gnt_r   <= gnt_nxt;
          end
        end
        TFC_BUSY: begin
          if (xfer_done_in || xfer_addr_err_in) begin
            state_r <= TFC_IDLE;
          end
        end
        default: state_r <= TFC_IDLE;
      endcase
    end
  end

  assign xfer_req_out  = (state_r == TFC_BUSY);
  assign xfer_ch_out   = gnt_r;
  // Unit size from the size field
  assign xfer_size_out = ts_r[gnt_r];

  // Served channel drops to the bottom, cyclic order kept
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      top_r     <= 2'h0;
      lock_v_r  <= 1'b0;
      lock_ch_r <= 2'h0;
    end else if (done) begin
      top_r     <= 2'(gnt_r + 2'h1);
      lock_v_r  <= burst_r[gnt_r] & (cnt_g != 24'h00_0001);
      lock_ch_r <= gnt_r;
    end
  end

  // Withdraw at first unit in cycle steal, at last in burst
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      withdraw_r <= 4'h0;
    end else begin
      withdraw_r <= 4'h0;
      if (done && rs_r[gnt_r][3:2] == RS_PERIPH_HI &&
          (!burst_r[gnt_r] || cnt_g == 24'h00_0001)) begin
        withdraw_r[rs_r[gnt_r][1:0]] <= 1'b1;
      end
    end
  end
  assign periph_withdraw_out = withdraw_r;

  // APB decode; zero wait states, unmapped offsets answer with an error
  assign a_ch        = paddr_in[5:4];
  assign hit_cnt     = (paddr_in[7:6] == 2'h0) & (paddr_in[3:0] == OFS_COUNT);
  assign hit_ctl     = (paddr_in[7:6] == 2'h0) & (paddr_in[3:0] == OFS_CTRL);
  assign hit_op      = (paddr_in == OFS_OPER);
  assign hit_any     = hit_cnt | hit_ctl | hit_op;
  assign wr_acc      = psel_in & penable_in & pwrite_in & hit_any;
  assign rd_setup    = psel_in & ~penable_in & ~pwrite_in;
  assign pready_out  = 1'b1;
  assign pslverr_out = psel_in & penable_in & ~hit_any;
  assign rd_mux      = hit_cnt ? {8'h00, cnt_r[a_ch]} :
                       hit_ctl ? {20'h0_0000, rs_r[a_ch], 1'b0, ts_r[a_ch], burst_r[a_ch],
                                  ds_r[a_ch], ie_r[a_ch], te_r[a_ch], ce_r[a_ch]} :
                       hit_op  ? {22'h00_0000, pr_r, 5'h00, aef_r, nmi_flag_r, me_r} :
                       32'h0000_0000;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      rdata_r <= 32'h0000_0000;
    end else if (rd_setup) begin
      rdata_r <= rd_mux;
    end
  end
  assign prdata_out = rdata_r;

  // Channel registers; hardware updates override a same-cycle write
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < NCH; i++) begin
        cnt_r[i] <= COUNT_RST;
        ts_r[i]  <= CTRL_RST[CTL_TS_LO +: 2];
        rs_r[i]  <= CTRL_RST[CTL_RS_LO +: 4];
      end
      ce_r    <= '0;
      te_r    <= '0;
      ie_r    <= '0;
      ds_r    <= '0;
      burst_r <= '0;
    end else begin
      if (wr_acc && hit_cnt) begin
        cnt_r[a_ch] <= pwdata_in[CNT_W-1:0];
      end
      if (wr_acc && hit_ctl) begin
        ce_r[a_ch]    <= pwdata_in[CTL_CE];
        ie_r[a_ch]    <= pwdata_in[CTL_IE];
        ds_r[a_ch]    <= pwdata_in[CTL_DS];
        burst_r[a_ch] <= pwdata_in[CTL_BURST];
        ts_r[a_ch]    <= pwdata_in[CTL_TS_LO +: 2];
        rs_r[a_ch]    <= pwdata_in[CTL_RS_LO +: 4];
        if (!pwdata_in[CTL_TE]) begin
          te_r[a_ch] <= 1'b0;
        end
      end
      // Count down; end flag at zero wins over a clear
      if (done) begin
        cnt_r[gnt_r] <= CNT_W'(cnt_g - 24'h00_0001);
        if (cnt_g == 24'h00_0001) begin
          te_r[gnt_r] <= 1'b1;
        end
      end
    end
  end

  // Flags set by events only, cleared by 0 after 1 was read
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      me_r        <= OPER_RST[OP_ME];
      pr_r        <= OPER_RST[OP_PR_LO +: 2];
      nmi_flag_r      <= OPER_RST[OP_NMI_FLAG];
      aef_r       <= OPER_RST[OP_AEF];
      nmi_flag_seen_r <= 1'b0;
      aef_seen_r  <= 1'b0;
    end else begin
      if (rd_setup && hit_op) begin
        nmi_flag_seen_r <= nmi_flag_r;
        aef_seen_r  <= aef_r;
      end
      if (wr_acc && hit_op) begin
        me_r <= pwdata_in[OP_ME];
        pr_r <= pwdata_in[OP_PR_LO +: 2];
        if (!pwdata_in[OP_NMI_FLAG] && nmi_flag_seen_r) begin
          nmi_flag_r      <= 1'b0;
          nmi_flag_seen_r <= 1'b0;
        end
        if (!pwdata_in[OP_AEF] && aef_seen_r) begin
          aef_r      <= 1'b0;
          aef_seen_r <= 1'b0;
        end
      end
      if (nmi_s2_r && !nmi_prev_r) begin
        nmi_flag_r <= 1'b1;
      end
      if (state_r == TFC_BUSY && xfer_addr_err_in) begin
        aef_r <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  enable_gate_a: assert property (start |-> ready[gnt_nxt] && ce_r[gnt_nxt] && me_r)
    else $error("Grant given to a channel that is not enabled");
  count_dec_a: assert property (done |=> cnt_r[$past(gnt_r)] == $past(cnt_g) - 24'h00_0001)
    else $error("Count not decremented after a unit");
  end_flag_a: assert property (done && cnt_g == 24'h00_0001 |=> te_r[$past(gnt_r)])
    else $error("End flag not set when count reached zero");
  halt_all_a: assert property ((nmi_flag_r || aef_r || !me_r) |-> !start)
    else $error("Transfer started while suspended");
  one_grant_a: assert property ($onehot0(request_acknowledge_out))
    else $error("More than one channel acknowledged");
  fixed_order_a: assert property (start && pr_r == 2'h0 && !lock_v_r && ready[0]
                                  |=> gnt_r == 2'h0)
    else $error("Fixed order zero skipped channel 0");
  rr_rotate_a: assert property (done |=> top_r == 2'($past(gnt_r) + 2'h1))
    else $error("Round robin did not move served channel to bottom");
  irq_block_a: assert property (periph_used[0] |-> !periph_irq_out[0])
    else $error("Request signal leaked to processor");
  steal_withdraw_a: assert property (done && !burst_r[gnt_r] && rs_r[gnt_r] == 4'hF
                                     |=> periph_withdraw_out[3])
    else $error("Cycle steal request not withdrawn at first unit");

endmodule

// file: rtl/tfc_pkg.sv
// Package of the four-channel transfer controller: register map, field
// positions, reset values, request codes and the fixed priority orders.
// Assumes a 32-bit APB slave port with byte addresses.
package tfc_pkg;

  localparam int          NCH          = 4;
  localparam int          CNT_W        = 24;

  // Register offsets (byte addresses); channel c sits at c * CH_STRIDE
  localparam logic [7:0]  CH_STRIDE    = 8'h10;
  localparam logic [3:0]  OFS_COUNT    = 4'h0;
  localparam logic [3:0]  OFS_CTRL     = 4'h4;
  localparam logic [7:0]  OFS_OPER     = 8'h40;

  // Channel control field positions
  localparam int          CTL_CE       = 0;
  localparam int          CTL_TE       = 1;
  localparam int          CTL_IE       = 2;
  localparam int          CTL_DS       = 3;
  localparam int          CTL_BURST    = 4;
  localparam int          CTL_TS_LO    = 5;
  localparam int          CTL_RS_LO    = 8;

  // Operation register field positions
  localparam int          OP_ME        = 0;
  localparam int          OP_NMI_FLAG      = 1;
  localparam int          OP_AEF       = 2;
  localparam int          OP_PR_LO     = 8;

  // Reset values
  localparam logic [31:0] CTRL_RST     = 32'h0000_0000;
  localparam logic [31:0] OPER_RST     = 32'h0000_0000;
  localparam logic [CNT_W-1:0] COUNT_RST = 24'h00_0000;

  // Request source codes
  localparam logic [3:0]  RS_EXT_DUAL  = 4'h0;
  localparam logic [3:0]  RS_EXT_M2D   = 4'h2;
  localparam logic [3:0]  RS_EXT_D2M   = 4'h3;
  localparam logic [3:0]  RS_AUTO      = 4'h4;
  localparam logic [1:0]  RS_PERIPH_HI = 2'h3;
  localparam logic [1:0]  SRC_TX       = 2'h0;
  localparam logic [1:0]  SRC_RX       = 2'h1;
  localparam logic [1:0]  SRC_ADC      = 2'h2;
  localparam logic [1:0]  SRC_CMT      = 2'h3;

  // Priority modes; each fixed order packs channel of position p at [2p+1:2p]
  localparam logic [1:0]  PR_RR        = 2'h3;
  localparam logic [7:0]  ORDER_0      = 8'hE4;
  localparam logic [7:0]  ORDER_1      = 8'h78;
  localparam logic [7:0]  ORDER_2      = 8'hD2;

  typedef enum logic [0:0] {
    TFC_IDLE = 1'b0,
    TFC_BUSY = 1'b1
  } tfc_state_t;

endpackage

// file: rtl/tfc_req_detect.sv
// External request detector of one channel: synchroniser, low-level or
// falling-edge detection, and a pending flag held until the unit is served.
// Assumes the request pin is asynchronous to clk_in.
`timescale 1ns/100ps
module tfc_req_detect (
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  input  wire logic req_n_in,
  input  wire logic edge_mode_in,
  input  wire logic served_in,
  output logic      req_out
);
  logic sync1_r;
  logic sync2_r;
  logic prev_r;
  logic pend_r;
  logic fall;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      sync1_r <= 1'b1;
      sync2_r <= 1'b1;
      prev_r  <= 1'b1;
    end else begin
      sync1_r <= req_n_in;
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
    end
  end

  assign fall = prev_r & ~sync2_r;

  // Edge held pending; a new edge beats the serve clear
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || !edge_mode_in) begin
      pend_r <= 1'b0;
    end else if (fall) begin
      pend_r <= 1'b1;
    end else if (served_in) begin
      pend_r <= 1'b0;
    end
  end

  assign req_out = edge_mode_in ? pend_r : ~sync2_r;

endmodule

// file: testbench/tb.sv
// Self-checking bench of the transfer controller: APB set-up, grant order
// table, then error, NMI, suspension, external and peripheral requests.
// Assumes the bus model of tfc_bus_model and a zero-wait APB slave.
`timescale 1ns/100ps
module tb;
  import tfc_pkg::*;
  typedef struct packed {
    logic [1:0]  pr;
    logic [7:0]  cnt;
    logic [3:0]  n;
    logic [3:0]  m;
    logic [15:0] sq;
  } tfc_row_t;

  logic        clk;
  logic        rst_n   = 1'b0;
  logic        psel    = 1'b0;
  logic        pen     = 1'b0;
  logic        pwr     = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic        nmi     = 1'b0;
  logic [3:0]  ext_n   = 4'hF;
  logic [3:0]  per     = 4'h0;
  logic [2:0]  lat     = 3'h0;
  logic        erm     = 1'b0;
  logic [31:0] prdata, prd;
  logic        pready, slv, pslverr, xreq, done, aerr;
  logic [1:0]  xch, xsz;
  logic [3:0]  irq, wdr, ack, tei, wacc, em;
  logic [15:0] seq;
  tfc_row_t    r;
  int          ng, cyc, miscompares, cmp_count;
  tfc_row_t    rows [6] = '{
    '{2'h3, 8'h46, 4'h4, 4'hB, 16'h0034},
    '{2'h0, 8'h55, 4'h4, 4'hF, 16'h00E4},
    '{2'h1, 8'h55, 4'h4, 4'hF, 16'h0078},
    '{2'h2, 8'h55, 4'h4, 4'hF, 16'h00D2},
    '{2'h1, 8'h44, 4'h2, 4'hA, 16'h0007},
    '{2'h3, 8'h55, 4'h4, 4'hF, 16'h004E}};

  tfc_core dut (
    .clk_in(clk), .rst_n_in(rst_n), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .external_request_n_in(ext_n), .nmi_in(nmi),
    .serial_tx_empty_req_in(per[0]), .serial_rx_full_req_in(per[1]),
    .conversion_end_req_in(per[2]), .compare_match_req_in(per[3]),
    .periph_irq_out(irq), .periph_withdraw_out(wdr), .xfer_req_out(xreq),
    .xfer_ch_out(xch), .xfer_size_out(xsz), .xfer_done_in(done),
    .xfer_addr_err_in(aerr), .request_acknowledge_out(ack),
    .transfer_end_interrupt_out(tei));

  tfc_bus_model bus (
    .clk_in(clk), .rst_n_in(rst_n), .req_in(xreq), .lat_in(lat),
    .err_in(erm), .done_out(done), .err_out(aerr));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task close_out();
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask

  // Setup cycle, then access until pready; request released only after it
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel   <= 1'b1;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    prd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask

  task wt(input int n);
    repeat (n) @(posedge clk);
  endtask

  function automatic logic [7:0] ra(input logic [1:0] c, input logic [3:0] o);
    return {2'h0, c, o};
  endfunction

  function automatic logic [31:0] cv(input logic [3:0] rs, input logic sel);
    return (32'(rs) << CTL_RS_LO) | (32'(sel) << CTL_DS) | (32'h1 << CTL_IE) | 32'h1;
  endfunction

  function automatic logic [31:0] ov(input logic me, input logic [1:0] pr);
    return (32'(pr) << OP_PR_LO) | (32'(me) << OP_ME);
  endfunction

  // Grant log, withdraw log, peripheral drop on withdraw, and hang limit
  always @(posedge clk) begin
    cyc++;
    wacc |= wdr;
    if (wdr !== 4'h0) per <= per & ~wdr;
    if (xreq === 1'b1 && done === 1'b1) begin
      seq[2*ng +: 2] = xch;
      ng++;
    end
    if (cyc == 30000) begin
      miscompares++;
      close_out();
    end
  end

  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'h0, OFS_OPER, 32'h0);
    chk("oper", prd, OPER_RST);
    apb(1'h0, ra(2'h0, OFS_CTRL), 32'h0);
    chk("ctrl0", prd, CTRL_RST);
    apb(1'h0, 8'h48, 32'h0);
    chk("slverr", {31'h0, slv}, 32'h1);
    foreach (rows[i]) begin
      r = rows[i];
      ng = 0;
      seq = 16'h0;
      lat <= 3'(i);
      for (int c = 0; c < NCH; c++) begin
        apb(1'h1, ra(2'(c), OFS_COUNT), 32'(r.cnt[2*c +: 2]));
        apb(1'h1, ra(2'(c), OFS_CTRL), r.m[c] ? cv(RS_AUTO, 1'h0) : 32'h0);
      end
      apb(1'h1, OFS_OPER, ov(1'h1, r.pr));
      while (ng < int'(r.n)) @(posedge clk);
      wt(4);
      chk("order", 32'(seq), 32'(r.sq));
      chk("tei", 32'(tei), 32'(r.m));
      apb(1'h0, ra(2'h3, OFS_COUNT), 32'h0);
      chk("cnt3", prd, 32'h0);
      apb(1'h1, OFS_OPER, 32'h0);
    end
    lat <= 3'h1;
    erm <= 1'b1;
    apb(1'h1, ra(2'h0, OFS_COUNT), 32'h3);
    apb(1'h1, ra(2'h0, OFS_CTRL), cv(RS_AUTO, 1'h0));
    apb(1'h1, OFS_OPER, ov(1'h1, 2'h0));
    wt(20);
    erm <= 1'b0;
    apb(1'h0, ra(2'h0, OFS_COUNT), 32'h0);
    chk("aecnt", prd, 32'h3);
    apb(1'h1, OFS_OPER, ov(1'h1, 2'h0));
    apb(1'h0, OFS_OPER, 32'h0);
    chk("aeflag", prd, ov(1'h1, 2'h0) | (32'h1 << OP_AEF));
    ng = 0;
    apb(1'h1, OFS_OPER, ov(1'h1, 2'h0));
    apb(1'h0, OFS_OPER, 32'h0);
    chk("aeclr", prd, ov(1'h1, 2'h0));
    while (ng < 3) @(posedge clk);
    apb(1'h1, OFS_OPER, 32'h0);
    nmi <= 1'b1;
    wt(4);
    nmi <= 1'b0;
    apb(1'h1, ra(2'h0, OFS_COUNT), 32'h2);
    apb(1'h1, ra(2'h0, OFS_CTRL), cv(RS_AUTO, 1'h0));
    ng = 0;
    apb(1'h1, OFS_OPER, ov(1'h1, 2'h0));
    wt(20);
    chk("nmiblk", 32'(ng), 32'h0);
    apb(1'h0, OFS_OPER, 32'h0);
    chk("nmi_flag", prd, ov(1'h1, 2'h0) | (32'h1 << OP_NMI_FLAG));
    apb(1'h1, OFS_OPER, ov(1'h1, 2'h0));
    while (ng < 2) @(posedge clk);
    lat <= 3'h6;
    ng = 0;
    apb(1'h1, ra(2'h0, OFS_COUNT), 32'h4);
    apb(1'h1, ra(2'h0, OFS_CTRL), cv(RS_AUTO, 1'h0) | (32'h2 << CTL_TS_LO));
    while (xreq !== 1'b1) @(posedge clk);
    chk("size", 32'(xsz), 32'h2);
    apb(1'h1, OFS_OPER, 32'h0);
    wt(30);
    chk("susp", 32'(ng), 32'h1);
    apb(1'h1, ra(2'h0, OFS_CTRL), 32'h0);
    lat <= 3'h3;
    apb(1'h1, ra(2'h1, OFS_COUNT), 32'h3);
    apb(1'h1, ra(2'h1, OFS_CTRL), cv(RS_EXT_M2D, 1'h1));
    ext_n[1] <= 1'b0;
    wt(3);
    ext_n[1] <= 1'b1;
    wt(4);
    ng = 0;
    apb(1'h1, OFS_OPER, ov(1'h1, 2'h0));
    for (int k = 0; k < 3; k++) begin
      while (xreq !== 1'b1) @(posedge clk);
      ext_n[1] <= 1'b1;
      chk("ack", 32'(ack), k < 2 ? 32'h2 : 32'h0);
      while (ng <= k) @(posedge clk);
      wt(8);
      apb(1'h0, ra(2'h1, OFS_COUNT), 32'h0);
      chk("cnt1", prd, 32'(2 - k));
      if (k < 2) begin
        apb(1'h1, ra(2'h1, OFS_CTRL), cv(k == 0 ? RS_EXT_D2M : RS_EXT_DUAL, 1'h0));
        ext_n[1] <= 1'b0;
      end
    end
    chk("tei1", 32'(tei[1]), 32'h1);
    apb(1'h1, OFS_OPER, 32'h0);
    lat <= 3'h2;
    // Last source runs two burst units, so its withdraw waits for the last
    for (int s = 0; s < 4; s++) begin
      // All four peripheral request inputs driven high
      per <= 4'hF;
      em = 4'h1 << s;
      apb(1'h1, ra(2'h2, OFS_COUNT), 32'(1 + (s == 3)));
      // Size 0 units; source side set up to match the requester
      apb(1'h1, ra(2'h2, OFS_CTRL),
          cv({RS_PERIPH_HI, 2'(s)}, 1'h0) | (32'(s == 3) << CTL_BURST));
      wt(1);
      chk("irq", 32'(irq), 32'(4'hF ^ em));
      wacc = 4'h0;
      ng = 0;
      apb(1'h1, OFS_OPER, ov(1'h1, 2'h0));
      while (ng < 1) @(posedge clk);
      wt(2);
      chk("wdr1", 32'(wacc), s == 3 ? 32'h0 : 32'(em));
      while (ng < 1 + int'(s == 3)) @(posedge clk);
      wt(4);
      chk("wdr", 32'(wacc), 32'(em));
      chk("units", 32'(ng), 32'(1 + (s == 3)));
      apb(1'h1, OFS_OPER, 32'h0);
    end
    // NMI flag sets while halted; a mid-run reset clears every flag
    nmi <= 1'b1;
    wt(4);
    nmi <= 1'b0;
    apb(1'h0, OFS_OPER, 32'h0);
    chk("nmif2", prd, 32'h1 << OP_NMI_FLAG);
    rst_n <= 1'b0;
    wt(4);
    rst_n <= 1'b1;
    apb(1'h0, OFS_OPER, 32'h0);
    chk("rstop", prd, OPER_RST);
    chk("rsttei", 32'(tei), 32'h0);
    close_out();
  end
endmodule

// file: testbench/tfc_bus_model.sv
// Bus engine model: finishes each granted unit after a set latency.
// Assumes the controller holds its request until done or error is seen.
`timescale 1ns/100ps
module tfc_bus_model (
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       req_in,
  input  wire logic [2:0] lat_in,
  input  wire logic       err_in,
  output logic            done_out,
  output logic            err_out
);
  logic [2:0] cnt_r;
  logic       hit;

  // One answer per unit; a stale count must not answer the next grant
  assign hit      = req_in && (cnt_r == lat_in);
  assign done_out = hit && !err_in;
  assign err_out  = hit && err_in;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in || !req_in) begin
      cnt_r <= 3'h0;
    end else if (cnt_r != 3'h7) begin
      cnt_r <= cnt_r + 3'h1;
    end
  end
endmodule
